/* File: verilog/quad_wiper_i2c_slave.sv */
// two-wire slave giving access to four wiper position registers
`timescale 1ns/1ns
`include "wiper_defs.svh"
// What this block does
// - four independent 8-bit wiper registers, each alone sets one tap.
// - code 00h is nearest low terminal, FFh nearest high terminal.
// - all four wiper registers load 80h at reset.
// - address bytes 00h to 03h select wiper 0 to 3.
// - bytes travel most significant bit first both ways.
// - data line stays undriven after reset until a transfer needs it.
// - ignore traffic until a start; start during reset is ignored.
// - stop condition returns the slave to idle.
// - transmitter releases after eight bits; receiver pulls low on ninth.
// - acknowledge valid id byte, address byte and write data byte.
// - id valid when prefix and strap bits match; last bit is direction.
// - write is id, address, one data byte, stop, all acknowledged.
// - keep sending data while master acknowledges each byte.
// - read pointer starts at address, advances per byte, wraps 3 to 0.
// - wiper updates within 1 us of last data bit clock fall.
module quad_wiper_i2c_slave
    import wiper_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_strap_low,
    input wire logic addr_strap_high,
    output byte_t digital_pot_0,
    output byte_t digital_pot_1,
    output byte_t digital_pot_2,
    output byte_t digital_pot_3
);
    // device-type prefix; value is arbitrary
    localparam logic [4:0] DEV_PREFIX = 5'h0b;

    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic [1:0] st_s;
        logic scl_p;
        logic sda_p;
        slave_state_e state;
        byte_kind_e kind;
        logic [2:0] bitn;
        byte_t shift;
        logic ack_drive;
        logic reading;
        logic [1:0] ptr;
        logic wr_pend;
        logic [1:0] wr_sel;
        byte_t wr_data;
        logic oe;
    } slave_s;

    slave_s s_q;
    slave_s s_d;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [1:0] strap;
    byte_t rd_data;

    function automatic logic id_match(input byte_t b, input logic [1:0] sp);
        id_match = (b[`DEV_PREFIX_MSB:`DEV_PREFIX_LSB] == DEV_PREFIX) &&
            (b[`STRAP_MSB:`STRAP_LSB] == sp);
    endfunction : id_match

    assign scl_rise = s_q.scl_s[1] && !s_q.scl_p;
    assign scl_fall = !s_q.scl_s[1] && s_q.scl_p;
    // edges of data while clock high frame a transfer
    assign start_seen = s_q.scl_s[1] && s_q.scl_p && s_q.sda_p &&
        !s_q.sda_s[1];
    assign stop_seen = s_q.scl_s[1] && s_q.scl_p && !s_q.sda_p &&
        s_q.sda_s[1];

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        s_d.wr_pend = 1'b0;
        s_d.scl_s = {s_q.scl_s[0], scl_in};
        s_d.sda_s = {s_q.sda_s[0], sda_in};
        s_d.st_s = {s_q.st_s[0], addr_strap_high};
        s_d.st_s[0] = addr_strap_high;
        s_d.scl_p = s_q.scl_s[1];
        s_d.sda_p = s_q.sda_s[1];
        if (start_seen) begin
            // repeated start keeps the pointer for reads
            s_d.state = ST_RX;
            s_d.kind = BY_ID;
            s_d.bitn = 3'h0;
            s_d.oe = 1'b0;
        end else if (stop_seen) begin
            s_d.state = ST_IDLE;
            s_d.oe = 1'b0;
        end else begin
            case (s_q.state)
                ST_IDLE, ST_IGNORE: begin
                    s_d.oe = 1'b0;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        s_d.shift = {s_q.shift[6:0], s_q.sda_s[1]};
                        s_d.bitn = s_q.bitn + 3'h1;
                        if (s_q.bitn == 3'h7) begin
                            s_d.state = ST_ACK;
                            s_d.ack_drive = 1'b0;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall && !s_q.ack_drive) begin
                        s_d.ack_drive = 1'b1;
                        case (s_q.kind)
                            BY_ID: begin
                                if (id_match(s_q.shift, strap)) begin
                                    s_d.oe = 1'b1;
                                    s_d.reading = s_q.shift[`RW_BIT];
                                end else begin
                                    s_d.state = ST_IGNORE;
                                end
                            end
                            BY_ADDR: begin
                                s_d.oe = 1'b1;
                                s_d.ptr = s_q.shift[1:0];
                            end
                            default: begin
                                s_d.oe = 1'b1;
                                s_d.wr_pend = 1'b1;
                                s_d.wr_sel = s_q.ptr;
                                s_d.wr_data = s_q.shift;
                            end
                        endcase
                    end else if (scl_fall && s_q.ack_drive) begin
                        s_d.oe = 1'b0;
                        s_d.bitn = 3'h0;
                        if (s_q.kind == BY_ID && s_q.reading) begin
                            s_d.state = ST_TX;
                            s_d.shift = rd_data;
                            s_d.oe = !rd_data[7];
                            s_d.ptr = s_q.ptr + 2'h1;
                        end else if (s_q.kind == BY_ID) begin
                            s_d.state = ST_RX;
                            s_d.kind = BY_ADDR;
                        end else if (s_q.kind == BY_ADDR) begin
                            s_d.state = ST_RX;
                            s_d.kind = BY_DATA;
                        end else begin
                            s_d.state = ST_IGNORE;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        s_d.bitn = s_q.bitn + 3'h1;
                        s_d.shift = {s_q.shift[6:0], 1'b0};
                        if (s_q.bitn == 3'h7) begin
                            s_d.oe = 1'b0;
                            s_d.state = ST_MACK;
                        end else begin
                            s_d.oe = !s_q.shift[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        if (s_q.sda_s[1]) begin
                            s_d.state = ST_IGNORE;
                        end else begin
                            s_d.ack_drive = 1'b1;
                        end
                    end else if (scl_fall && s_q.ack_drive) begin
                        s_d.ack_drive = 1'b0;
                        s_d.state = ST_TX;
                        s_d.bitn = 3'h0;
                        s_d.shift = rd_data;
                        s_d.oe = !rd_data[7];
                        s_d.ptr = s_q.ptr + 2'h1;
                    end
                end
                default: begin
                    s_d.state = ST_IDLE;
                end
            endcase
        end
        if (s_q.state == ST_MACK && scl_rise) begin
            s_d.ack_drive = !s_q.sda_s[1];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '{scl_s: 2'h3, sda_s: 2'h3, st_s: 2'h0, scl_p: 1'b1,
                sda_p: 1'b1, state: ST_IDLE, kind: BY_ID, bitn: 3'h0,
                shift: 8'h00, ack_drive: 1'b0, reading: 1'b0, ptr: 2'h0,
                wr_pend: 1'b0, wr_sel: 2'h0, wr_data: 8'h00, oe: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [1:0] strap_lo_s;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            strap_lo_s <= 2'h0;
        end else begin
            strap_lo_s <= {strap_lo_s[0], addr_strap_low};
        end
    end
    // strap order matches id byte bits 2 and 1
    assign strap = {s_q.st_s[1], strap_lo_s[1]};

    // open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe = s_q.oe;

    wiper_regs u_regs (
        .clock(clock),
        .rst_n(rst_n),
        .wr_en(s_q.wr_pend),
        .wr_sel(s_q.wr_sel),
        .wr_data(s_q.wr_data),
        .rd_sel(s_q.ptr),
        .rd_data(rd_data),
        .pos_0(digital_pot_0),
        .pos_1(digital_pot_1),
        .pos_2(digital_pot_2),
        .pos_3(digital_pot_3)
    );

    ////////////////////////////////////////////////////////////////////////
    sequence seq_data_ack;
        s_q.state == ST_ACK && s_q.kind == BY_DATA && scl_fall &&
            !s_q.ack_drive;
    endsequence

    AST_WRITE_LANDS: assert property (@(posedge clock) disable iff (!rst_n)
        seq_data_ack |=> ##1 1'b1 ##[0:2] (digital_pot_0 == s_q.wr_data ||
        digital_pot_1 == s_q.wr_data || digital_pot_2 == s_q.wr_data ||
        digital_pot_3 == s_q.wr_data))
        else $error("written data did not reach a wiper");

    AST_IDLE_RELEASE: assert property (@(posedge clock) disable iff (!rst_n)
        s_q.state == ST_IDLE |-> !sda_oe)
        else $error("data line driven while idle");

    AST_STOP_IDLE: assert property (@(posedge clock) disable iff (!rst_n)
        stop_seen && !start_seen |=> s_q.state == ST_IDLE)
        else $error("stop did not return to idle");

    AST_START_RX: assert property (@(posedge clock) disable iff (!rst_n)
        start_seen |=> s_q.state == ST_RX && s_q.kind == BY_ID)
        else $error("start did not open id byte");

    AST_NO_ACK_MISMATCH: assert property (@(posedge clock)
        disable iff (!rst_n)
        s_q.state == ST_ACK && s_q.kind == BY_ID && scl_fall &&
        !s_q.ack_drive && !id_match(s_q.shift, strap) && !start_seen &&
        !stop_seen |=> !sda_oe && s_q.state == ST_IGNORE)
        else $error("mismatched id acknowledged");

    AST_IGNORE_QUIET: assert property (@(posedge clock) disable iff (!rst_n)
        s_q.state == ST_IGNORE |-> !sda_oe)
        else $error("bus driven while ignoring");

    AST_PTR_WRAP: assert property (@(posedge clock) disable iff (!rst_n)
        s_q.state == ST_MACK && scl_fall && s_q.ack_drive && !start_seen &&
        !stop_seen && s_q.ptr == `WIPER_ADDR_LAST |=> s_q.ptr == 2'h0)
        else $error("pointer did not wrap");

    AST_RELEASE_AFTER8: assert property (@(posedge clock)
        disable iff (!rst_n)
        s_q.state == ST_TX && scl_fall && s_q.bitn == 3'h7 && !start_seen &&
        !stop_seen |=> !sda_oe && s_q.state == ST_MACK)
        else $error("transmitter kept line after eight bits");
endmodule : quad_wiper_i2c_slave

/* File: verilog/wiper_defs.svh */
// constants for the quad wiper two-wire slave
`ifndef WIPER_DEFS_SVH
`define WIPER_DEFS_SVH
`define WIPER_RESET_VALUE 8'h80
`define WIPER_COUNT 4
`define WIPER_ADDR_0 8'h00
`define WIPER_ADDR_1 8'h01
`define WIPER_ADDR_2 8'h02
`define WIPER_ADDR_3 8'h03
`define WIPER_ADDR_LAST 2'h3
`define DEV_PREFIX_MSB 7
`define DEV_PREFIX_LSB 3
`define STRAP_MSB 2
`define STRAP_LSB 1
`define RW_BIT 0
`define CLK_PERIOD_NS 50
`define WIPER_RESPONSE_NS 1000
`define WIPER_RESPONSE_CYC (`WIPER_RESPONSE_NS / `CLK_PERIOD_NS)
`endif

/* File: verilog/wiper_pkg.sv */
// types for the quad wiper two-wire slave
package wiper_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_MACK,
        ST_IGNORE
    } slave_state_e;
    typedef enum logic [1:0] {
        BY_ID,
        BY_ADDR,
        BY_DATA
    } byte_kind_e;
    typedef logic [7:0] byte_t;
endpackage : wiper_pkg

/* File: verilog/wiper_regs.sv */
// four wiper position registers with registered read port
`timescale 1ns/1ns
`include "wiper_defs.svh"
module wiper_regs
    import wiper_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wr_en,
    input wire logic [1:0] wr_sel,
    input wire byte_t wr_data,
    input wire logic [1:0] rd_sel,
    output byte_t rd_data,
    output byte_t pos_0,
    output byte_t pos_1,
    output byte_t pos_2,
    output byte_t pos_3
);
    typedef struct packed {
        byte_t [3:0] pos;
        byte_t rd;
    } regs_s;
    regs_s s_q;
    regs_s s_d;

    always_comb begin
        s_d = s_q;
        if (wr_en) begin
            s_d.pos[wr_sel] = wr_data;
        end
        s_d.rd = s_q.pos[rd_sel];
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= {5{`WIPER_RESET_VALUE}};
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data = s_q.rd;
    assign pos_0 = s_q.pos[0];
    assign pos_1 = s_q.pos[1];
    assign pos_2 = s_q.pos[2];
    assign pos_3 = s_q.pos[3];
endmodule : wiper_regs

/* File: bench/i2c_master_model.sv */
// two-wire bus master model that drives the serial clock and data
`timescale 1ns/1ns
module i2c_master_model
    import wiper_pkg::*;
(
    input wire logic clock,
    input wire logic sda_line,
    output logic scl,
    output logic sda_drv
);
    // serial clock stands high between frames; released data is pulled up
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic half_bit();
        repeat (4) @(posedge clock);
    endtask : half_bit

    // parks the serial clock low without touching data
    task automatic clock_low();
        scl <= 1'b0;
        half_bit();
    endtask : clock_low

    // also used as repeated start
    task automatic start();
        sda_drv <= 1'b1;
        half_bit();
        scl <= 1'b1;
        half_bit();
        sda_drv <= 1'b0;
        half_bit();
        scl <= 1'b0;
        half_bit();
    endtask : start

    task automatic stop();
        sda_drv <= 1'b0;
        half_bit();
        scl <= 1'b1;
        half_bit();
        sda_drv <= 1'b1;
        half_bit();
    endtask : stop

    task automatic clk_bit(input logic b, output logic r);
        sda_drv <= b;
        half_bit();
        scl <= 1'b1;
        half_bit();
        r = sda_line;
        scl <= 1'b0;
        half_bit();
    endtask : clk_bit

    // tx of ff releases the line so the slave can send
    task automatic xfer(input byte_t tx, input logic ack_out,
                        output byte_t rx, output logic ack_in);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(tx[i], b);
            rx[i] = b;
        end
        clk_bit(ack_out, ack_in);
    endtask : xfer
endmodule : i2c_master_model

/* File: bench/tb.sv */
// self-checking bench for the quad wiper two-wire slave
`timescale 1ns/1ns
module tb
    import wiper_pkg::*;
;
    // arbitrary device-type prefix; must equal the design's
    localparam logic [4:0] dev_prefix = 5'h0b;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic strap_lo = 1'b1;
    logic strap_hi = 1'b0;
    wire logic scl;
    wire logic sda_drv;
    wire logic sda_out;
    wire logic sda_oe;
    wire logic sda_line;
    wire byte_t pots [4];
    byte_t vals [4] = '{8'h00, 8'hff, 8'h5a, 8'hc3};
    int err_count = 0;
    int compares = 0;

    always #25 clock = ~clock;
    assign sda_line = sda_drv & ~(sda_oe & ~sda_out);

    quad_wiper_i2c_slave u_dut (
        .clock(clock), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_low(strap_lo),
        .addr_strap_high(strap_hi), .digital_pot_0(pots[0]),
        .digital_pot_1(pots[1]), .digital_pot_2(pots[2]),
        .digital_pot_3(pots[3])
    );
    i2c_master_model u_master (
        .clock(clock), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic byte_t idb(input logic rw);
        return {dev_prefix, strap_hi, strap_lo, rw};
    endfunction : idb

    task automatic wr(input byte_t addr, input byte_t data);
        byte_t rx;
        logic a;
        u_master.start();
        u_master.xfer(idb(1'b0), 1'b1, rx, a);
        chk({7'h00, a}, 8'h00);
        u_master.xfer(addr, 1'b1, rx, a);
        chk({7'h00, a}, 8'h00);
        u_master.xfer(data, 1'b1, rx, a);
        chk({7'h00, a}, 8'h00);
        chk(pots[addr[1:0]], data);
        u_master.stop();
    endtask : wr

    ////////////////////////////////////////////////////////////////////////
    task automatic check_reset();
        for (int i = 0; i < 4; i++) chk(pots[i], 8'h80);
        chk({7'h00, sda_oe}, 8'h00);
    endtask : check_reset

    task automatic write_all();
        for (int i = 0; i < 4; i++) wr(8'(i), vals[i]);
        for (int i = 0; i < 4; i++) chk(pots[i], vals[i]);
    endtask : write_all

    task automatic read_wrap();
        byte_t rx;
        logic a;
        u_master.start();
        u_master.xfer(idb(1'b0), 1'b1, rx, a);
        chk({7'h00, a}, 8'h00);
        u_master.xfer(8'h02, 1'b1, rx, a);
        chk({7'h00, a}, 8'h00);
        u_master.start();
        u_master.xfer(idb(1'b1), 1'b1, rx, a);
        chk({7'h00, a}, 8'h00);
        for (int k = 0; k < 5; k++) begin
            u_master.xfer(8'hff, k == 4, rx, a);
            chk(rx, vals[(2 + k) % 4]);
        end
        u_master.stop();
    endtask : read_wrap

    task automatic bad_id();
        byte_t rx;
        logic a;
        u_master.start();
        u_master.xfer(idb(1'b0) ^ 8'h80, 1'b1, rx, a);
        chk({7'h00, a}, 8'h01);
        u_master.xfer(8'h01, 1'b1, rx, a);
        chk({7'h00, a}, 8'h01);
        u_master.stop();
        strap_hi <= 1'b1;
        u_master.start();
        u_master.xfer(idb(1'b0) ^ 8'h04, 1'b1, rx, a);
        chk({7'h00, a}, 8'h01);
        u_master.stop();
        wr(8'h01, 8'h33);
        chk(pots[0], vals[0]);
        vals[1] = 8'h33;
    endtask : bad_id

    task automatic no_start();
        byte_t rx;
        logic a;
        u_master.clock_low();
        u_master.xfer(idb(1'b0), 1'b1, rx, a);
        chk({7'h00, a}, 8'h01);
        u_master.stop();
        wr(8'h07, 8'h11);
        chk(pots[3], 8'h11);
    endtask : no_start

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge clock);
        err_count++;
        print_verdict();
    end

    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        check_reset();
        write_all();
        read_wrap();
        bad_id();
        no_start();
        print_verdict();
    end
endmodule : tb
